//--- design/pud_pkg.sv
/*
  Shared constants and carrier types for the presettable up/down binary counter.
  Assumes a single aclk domain and an AXI4-Lite master with 32-bit data.
*/
`default_nettype none

package pud_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned CNT_W  = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRESET = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

  localparam int unsigned CTRL_CLR_BIT   = 0;
  localparam int unsigned CTRL_LD_BIT    = 1;
  localparam int unsigned STAT_CARRY_BIT = 4;
  localparam int unsigned STRB_LOW_BYTE  = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // count values
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_TOP    = 4'hf;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic             CARRY_IDLE = 1'b1;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic count_clock;
    logic carry_in_n;
    logic up_down;
    logic parallel_load_enable;
    logic clear;
    logic load_value_bit_three;
    logic load_value_bit_two;
    logic load_value_bit_one;
    logic load_value_bit_zero;
  } pud_pins_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pud_axi_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } pud_axi_rsp_s;

  typedef struct packed {
    pud_pins_s        s1;
    pud_pins_s        s2;
    logic             clk_prev;
    logic [CNT_W-1:0] count;
    logic             carry_n;
    logic             sw_clear;
    logic             sw_load;
    logic [CNT_W-1:0] sw_preset;
    pud_axi_rsp_s     axi;
  } pud_state_s;

  localparam pud_state_s STATE_RESET = '{
    s1:        '0,
    s2:        '0,
    clk_prev:  1'b0,
    count:     CNT_BOTTOM,
    carry_n:   CARRY_IDLE,
    sw_clear:  1'b0,
    sw_load:   1'b0,
    sw_preset: CNT_BOTTOM,
    axi:       '0
  };

endpackage : pud_pkg

`default_nettype wire

//--- design/pud_counter.sv
/*
  Four-bit presettable up/down binary counter with AXI4-Lite control/status.
  Assumes all pins are asynchronous to aclk and are synchronised here; the
  count clock pin is sampled and its rising edges detected on aclk.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none

// Function
// - while load enable is high and clear is low the preset inputs are copied into the count, whatever the clock.
// - carry in is active low, and while it is high clock edges leave the count unchanged.
// - each enabled rising count clock edge adds or subtracts one from the four-bit count.
// - the count appears in plain binary on four outputs, bit zero the least significant.
// - carry out is an active-low terminal count flag derived synchronously from the count.
// - load enable is active high, asynchronous, and blocks counting while asserted.
// - clear is active high, asynchronous, forces the count to zero and blocks counting.
// - direction high counts up and direction low counts down.
// - once load enable falls, counting continues from the loaded value on later enabled edges.
// - carry out is low for one full count cycle at 15 counting up or 0 counting down.
// - each count bit is a toggle stage that flips on a rising edge only when its condition holds.
// - counting up, carry out is low only with all bits one and carry in low.
// - counting down, carry out is low only with all bits zero and carry in low.

module pud_counter (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire pud_pkg::pud_pins_s   pins,
  input  wire pud_pkg::pud_axi_req_s axi_req,
  output var  pud_pkg::pud_axi_rsp_s axi_rsp,
  output logic                      count_bit_zero,
  output logic                      count_bit_one,
  output logic                      count_bit_two,
  output logic                      count_bit_three,
  output logic                      carry_out_n
);

  // ****************************************************************
  // state
  // ****************************************************************
  pud_pkg::pud_state_s          st;
  pud_pkg::pud_state_s          next_st;
  logic [pud_pkg::CNT_W-1:0]    toggle;
  logic [pud_pkg::CNT_W-1:0]    pin_value;
  logic                         clk_rise;
  logic                         clr_any;
  logic                         ld_any;

  assign pin_value = {st.s2.load_value_bit_three, st.s2.load_value_bit_two,
                      st.s2.load_value_bit_one, st.s2.load_value_bit_zero};
  assign clk_rise  = st.s2.count_clock & ~st.clk_prev;
  assign clr_any   = st.s2.clear | st.sw_clear;
  assign ld_any    = st.s2.parallel_load_enable | st.sw_load;

  // ****************************************************************
  // toggle stages
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < pud_pkg::CNT_W; gi++) begin : g_tog
      if (gi == 0) begin : g_lsb
        assign toggle[gi] = 1'b1;
      end else begin : g_upper
        assign toggle[gi] = st.s2.up_down ? (&st.count[gi-1:0])
                                          : ~(|st.count[gi-1:0]);
      end
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st          = st;
    next_st.s1       = pins;
    next_st.s2       = st.s1;
    next_st.clk_prev = st.s2.count_clock;

    // count update, clear over load over counting
    if (clr_any) begin
      next_st.count = pud_pkg::CNT_BOTTOM;
    end else if (ld_any) begin
      next_st.count = st.s2.parallel_load_enable ? pin_value : st.sw_preset;
    end else if (clk_rise && !st.s2.carry_in_n) begin
      next_st.count = st.count ^ toggle;
    end else begin
      next_st.count = st.count;
    end

    // terminal count flag
    next_st.carry_n = !(!st.s2.carry_in_n &&
                        (st.s2.up_down ? (next_st.count == pud_pkg::CNT_TOP)
                                       : (next_st.count == pud_pkg::CNT_BOTTOM)));

    // write channel
    next_st.axi.awready = 1'b0;
    next_st.axi.wready  = 1'b0;
    if (st.axi.bvalid && axi_req.bready) begin
      next_st.axi.bvalid = 1'b0;
    end
    if (axi_req.awvalid && axi_req.wvalid && !st.axi.awready && !st.axi.bvalid) begin
      next_st.axi.awready = 1'b1;
      next_st.axi.wready  = 1'b1;
    end
    if (st.axi.awready) begin
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp  = pud_pkg::RESP_OKAY;
      case (axi_req.awaddr)
        pud_pkg::ADDR_CTRL: begin
          if (axi_req.wstrb[pud_pkg::STRB_LOW_BYTE]) begin
            next_st.sw_clear = axi_req.wdata[pud_pkg::CTRL_CLR_BIT];
            next_st.sw_load  = axi_req.wdata[pud_pkg::CTRL_LD_BIT];
          end
        end
        pud_pkg::ADDR_PRESET: begin
          if (axi_req.wstrb[pud_pkg::STRB_LOW_BYTE]) begin
            next_st.sw_preset = axi_req.wdata[pud_pkg::CNT_W-1:0];
          end
        end
        pud_pkg::ADDR_STATUS: begin
          next_st.axi.bresp = pud_pkg::RESP_OKAY;
        end
        default: begin
          next_st.axi.bresp = pud_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel
    next_st.axi.arready = 1'b0;
    if (st.axi.rvalid && axi_req.rready) begin
      next_st.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.axi.arready && !st.axi.rvalid) begin
      next_st.axi.arready = 1'b1;
    end
    if (st.axi.arready) begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rresp  = pud_pkg::RESP_OKAY;
      next_st.axi.rdata  = '0;
      case (axi_req.araddr)
        pud_pkg::ADDR_CTRL: begin
          next_st.axi.rdata[pud_pkg::CTRL_CLR_BIT] = st.sw_clear;
          next_st.axi.rdata[pud_pkg::CTRL_LD_BIT]  = st.sw_load;
        end
        pud_pkg::ADDR_PRESET: begin
          next_st.axi.rdata[pud_pkg::CNT_W-1:0] = st.sw_preset;
        end
        pud_pkg::ADDR_STATUS: begin
          next_st.axi.rdata[pud_pkg::CNT_W-1:0]      = st.count;
          next_st.axi.rdata[pud_pkg::STAT_CARRY_BIT] = st.carry_n;
        end
        default: begin
          next_st.axi.rresp = pud_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= pud_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign axi_rsp         = st.axi;
  assign count_bit_zero  = st.count[0];
  assign count_bit_one   = st.count[1];
  assign count_bit_two   = st.count[2];
  assign count_bit_three = st.count[3];
  assign carry_out_n     = st.carry_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_clear_forces_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st.s2.clear |=> (st.count == pud_pkg::CNT_BOTTOM)
  ) else $error("count not zero after clear");

  a_load_copies_pins: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st.s2.parallel_load_enable && !clr_any) |=> (st.count == $past(pin_value))
  ) else $error("count not equal to preset pins during load");

  a_cin_high_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st.s2.carry_in_n && !clr_any && !ld_any) |=> $stable(st.count)
  ) else $error("count moved while carry in high");

  a_count_up_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_rise && !st.s2.carry_in_n && st.s2.up_down && !clr_any && !ld_any)
      |=> (st.count == $past(st.count) + pud_pkg::CNT_ONE)
  ) else $error("count did not step up");

  a_count_down_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_rise && !st.s2.carry_in_n && !st.s2.up_down && !clr_any && !ld_any)
      |=> (st.count == $past(st.count) - pud_pkg::CNT_ONE)
  ) else $error("count did not step down");

  a_no_edge_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!clk_rise && !clr_any && !ld_any) |=> $stable(st.count)
  ) else $error("count moved without rising edge");

  a_carry_terminal: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !carry_out_n |-> ($past(!st.s2.carry_in_n) &&
      ($past(st.s2.up_down) ? (st.count == pud_pkg::CNT_TOP)
                            : (st.count == pud_pkg::CNT_BOTTOM)))
  ) else $error("carry out low away from terminal count");

  a_carry_one_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!carry_out_n && clk_rise && !st.s2.carry_in_n && !clr_any && !ld_any &&
     $stable(st.s2.up_down)) |=> carry_out_n
  ) else $error("carry out stayed low past one count cycle");

  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (axi_rsp.awready && axi_rsp.wready) |=> axi_rsp.bvalid
  ) else $error("no write response after handshake");

  a_soft_load_preset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st.sw_load && !st.s2.parallel_load_enable && !clr_any)
      |=> (st.count == $past(st.sw_preset))
  ) else $error("count not equal to software preset during load");

  a_soft_clear_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st.sw_clear |=> (st.count == pud_pkg::CNT_BOTTOM)
  ) else $error("count not zero after software clear");

  a_clear_beats_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clr_any && ld_any) |=> (st.count == pud_pkg::CNT_BOTTOM)
  ) else $error("load won over clear");

  a_carry_cin_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st.s2.carry_in_n |=> carry_out_n
  ) else $error("carry out low while carry in high");

  a_carry_up_top: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (aresetn && !st.s2.carry_in_n && st.s2.up_down)
      |=> (carry_out_n == (st.count != pud_pkg::CNT_TOP))
  ) else $error("carry out wrong while counting up");

  a_carry_down_bottom: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (aresetn && !st.s2.carry_in_n && !st.s2.up_down)
      |=> (carry_out_n == (st.count != pud_pkg::CNT_BOTTOM))
  ) else $error("carry out wrong while counting down");

  a_count_wrap_up: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_rise && !st.s2.carry_in_n && st.s2.up_down && !clr_any && !ld_any &&
     (st.count == pud_pkg::CNT_TOP)) |=> (st.count == pud_pkg::CNT_BOTTOM)
  ) else $error("count did not wrap from top to bottom");

  a_count_wrap_down: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_rise && !st.s2.carry_in_n && !st.s2.up_down && !clr_any && !ld_any &&
     (st.count == pud_pkg::CNT_BOTTOM)) |=> (st.count == pud_pkg::CNT_TOP)
  ) else $error("count did not wrap from bottom to top");

  a_lsb_toggles: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_rise && !st.s2.carry_in_n && !clr_any && !ld_any)
      |=> (st.count[0] != $past(st.count[0]))
  ) else $error("least significant bit did not toggle");

  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    axi_rsp.arready |=> axi_rsp.rvalid
  ) else $error("no read data after address handshake");

  a_bvalid_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (axi_rsp.bvalid && axi_req.bready) |=> !axi_rsp.bvalid
  ) else $error("write response stayed after it was taken");

  a_rvalid_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (axi_rsp.rvalid && axi_req.rready) |=> !axi_rsp.rvalid
  ) else $error("read data stayed after it was taken");

  a_awready_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    axi_rsp.awready |=> !axi_rsp.awready
  ) else $error("write ready longer than one cycle");

  a_arready_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    axi_rsp.arready |=> !axi_rsp.arready
  ) else $error("read ready longer than one cycle");

endmodule : pud_counter

`default_nettype wire

//--- verification/pud_far_end.sv
/*
  Far-side control model: makes bursts of count clock pulses on request.
  Assumes one aclk domain; pulses are 4 cycles low then 4 cycles high.
*/
`default_nettype none

module pud_far_end (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [3:0] n_pulses,
  output logic            count_clock,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  logic [2:0] ph;

  // clock stands low outside a burst
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left <= 4'h0;
      ph   <= 3'h0;
    end else if (go && left == 4'h0) begin
      left <= n_pulses;
      ph   <= 3'h0;
    end else if (left != 4'h0) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        left <= left - 4'h1;
      end
    end
  end
  assign count_clock = (left != 4'h0) && ph[2];
  assign busy        = left != 4'h0;
endmodule : pud_far_end

`default_nettype wire

//--- verification/presettable_updown_binary_counter_test.sv
/*
  Self-checking bench: table of count runs, clear/load cases, AXI4-Lite access.
  Assumes pud_far_end drives the count clock pin; aclk runs at 25 MHz.
*/
`default_nettype none

module presettable_updown_binary_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic                  aclk;
  logic                  aresetn;
  logic                  cc;
  logic                  busy;
  logic                  go;
  logic [3:0]            n_pulses;
  pud_pkg::pud_pins_s    pins_tb;
  pud_pkg::pud_pins_s    pins;
  pud_pkg::pud_axi_req_s req;
  pud_pkg::pud_axi_rsp_s rsp;
  wire logic [3:0]       cnt;
  logic                  carry_out_n;
  logic [1:0]            resp;
  logic [31:0]           rd;
  int                    mismatches;
  int                    n_tests;
  logic [14:0]           rows [6];

  always_comb begin
    pins             = pins_tb;
    pins.count_clock = cc;
  end

  pud_counter pud_counter_i (.aclk(aclk), .aresetn(aresetn), .pins(pins), .axi_req(req),
    .axi_rsp(rsp), .count_bit_zero(cnt[0]), .count_bit_one(cnt[1]),
    .count_bit_two(cnt[2]), .count_bit_three(cnt[3]), .carry_out_n(carry_out_n));

  pud_far_end pud_far_end_i (.aclk(aclk), .aresetn(aresetn), .go(go), .n_pulses(n_pulses),
    .count_clock(cc), .busy(busy));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic pulse(input logic [3:0] n);
    go       <= 1'b1;
    n_pulses <= n;
    cyc(1);
    go <= 1'b0;
    cyc(1);
    while (busy) cyc(1);
    cyc(5);
  endtask : pulse

  task automatic setv(input logic [3:0] v);
    pins_tb.load_value_bit_zero  <= v[0];
    pins_tb.load_value_bit_one   <= v[1];
    pins_tb.load_value_bit_two   <= v[2];
    pins_tb.load_value_bit_three <= v[3];
  endtask : setv

  task automatic load(input logic [3:0] v);
    setv(v);
    pins_tb.parallel_load_enable <= 1'b1;
    cyc(5);
    pins_tb.parallel_load_enable <= 1'b0;
    cyc(5);
  endtask : load

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    cyc(1);
    while (!(rsp.awready && rsp.wready)) cyc(1);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    cyc(1);
    while (!rsp.bvalid) cyc(1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    cyc(1);
  endtask : axw

  task automatic axr(input logic [3:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    cyc(1);
    while (!rsp.arready) cyc(1);
    req.arvalid <= 1'b0;
    cyc(1);
    while (!rsp.rvalid) cyc(1);
    rd   = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    cyc(1);
  endtask : axr

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    cyc(20000);
    mismatches++;
    final_report();
  end

  initial begin
    aresetn    <= 1'b0;
    pins_tb    <= '0;
    req        <= '0;
    go         = 1'b0;
    n_pulses   = 4'h0;
    mismatches = 0;
    n_tests    = 0;
    // up, carry in, load, pulses, count, carry out
    rows = '{{1'b1, 1'b0, 4'h3, 4'h2, 4'h5, 1'b1}, {1'b0, 1'b0, 4'h3, 4'h3, 4'h0, 1'b0},
             {1'b1, 1'b0, 4'he, 4'h1, 4'hf, 1'b0}, {1'b1, 1'b0, 4'hf, 4'h1, 4'h0, 1'b1},
             {1'b0, 1'b0, 4'h0, 4'h1, 4'hf, 1'b1}, {1'b1, 1'b1, 4'h7, 4'h2, 4'h7, 1'b1}};
    cyc(16);
    chk(cnt, 32'h0);
    chk(carry_out_n, 32'h1);
    aresetn <= 1'b1;
    cyc(5);
    chk(carry_out_n, 32'h0);
    $display("reset done");
    foreach (rows[i]) begin
      pins_tb.up_down    <= rows[i][14];
      pins_tb.carry_in_n <= rows[i][13];
      load(rows[i][12:9]);
      pulse(rows[i][8:5]);
      chk(cnt, rows[i][4:1]);
      chk(carry_out_n, rows[i][0]);
      $display("row %0d done", i);
    end
    pins_tb.carry_in_n           <= 1'b0;
    pins_tb.up_down              <= 1'b1;
    pins_tb.clear                <= 1'b1;
    pins_tb.parallel_load_enable <= 1'b1;
    setv(4'h9);
    cyc(5);
    chk(cnt, 32'h0);
    pins_tb.clear <= 1'b0;
    cyc(5);
    chk(cnt, 32'h9);
    pulse(4'h1);
    chk(cnt, 32'h9);
    pins_tb.parallel_load_enable <= 1'b0;
    cyc(5);
    pulse(4'h1);
    chk(cnt, 32'ha);
    pins_tb.clear <= 1'b1;
    pulse(4'h2);
    chk(cnt, 32'h0);
    pins_tb.clear <= 1'b0;
    cyc(5);
    $display("clear and load done");
    pins_tb.up_down <= 1'b0;
    load(4'h4);
    pulse(4'h4);
    chk(cnt, 32'h0);
    chk(carry_out_n, 32'h0);
    pulse(4'h1);
    chk(cnt, 32'hf);
    chk(carry_out_n, 32'h1);
    pins_tb.up_down <= 1'b1;
    cyc(5);
    $display("divider done");
    axw(pud_pkg::ADDR_PRESET, 32'h6);
    chk(resp, pud_pkg::RESP_OKAY);
    axw(pud_pkg::ADDR_CTRL, 32'h2);
    axw(pud_pkg::ADDR_CTRL, 32'h0);
    axr(pud_pkg::ADDR_STATUS);
    chk(rd, 32'h16);
    axw(pud_pkg::ADDR_CTRL, 32'h1);
    axr(pud_pkg::ADDR_STATUS);
    chk(rd, 32'h10);
    axw(pud_pkg::ADDR_CTRL, 32'h0);
    axw(4'hc, 32'h1);
    chk(resp, pud_pkg::RESP_SLVERR);
    axr(4'hc);
    chk(resp, pud_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    $display("register access done");
    axw(pud_pkg::ADDR_CTRL, 32'h2);
    cyc(2);
    chk(cnt, 32'h6);
    aresetn <= 1'b0;
    cyc(3);
    chk(cnt, 32'h0);
    chk(carry_out_n, 32'h1);
    aresetn <= 1'b1;
    cyc(5);
    axr(pud_pkg::ADDR_CTRL);
    chk(rd, 32'h0);
    chk(cnt, 32'h0);
    $display("mid-run reset done");
    final_report();
  end
endmodule : presettable_updown_binary_counter_test

`default_nettype wire
